/* src/msi_pkg.sv */
// Constants shared by the maintenance status and interrupt logic.
// Assumes a 10 MHz core clock and a 32-bit Avalon-MM register port.
package msi_pkg;

  // Clock rate
  localparam int          CLK_HZ            = 10_000_000;

  // Qualification period of in-band code detection
  localparam int          QUAL_SHORT_MS     = 40;
  // Long period in tenths of a second, kept integral so no rounding creeps in
  localparam int          QUAL_LONG_DS      = 51;
  localparam int          QUAL_SHORT_CYC    = (QUAL_SHORT_MS * CLK_HZ + 999) / 1000;
  localparam int          QUAL_LONG_CYC     = QUAL_LONG_DS * (CLK_HZ / 10);
  localparam int          QUAL_W            = 26;

  // Transmit clock loss threshold in core clock cycles
  localparam int          TXCLK_LOSS_CYC    = 70;
  localparam int          TXCLK_CNT_W       = 7;

  // Register byte addresses
  localparam int          ADDR_W            = 5;
  localparam logic [4:0]  REG_LIVE_STATUS   = 5'h00;
  localparam logic [4:0]  REG_CONTROL       = 5'h04;
  localparam logic [4:0]  REG_IRQ_STATUS    = 5'h08;
  localparam logic [4:0]  REG_IRQ_MASK      = 5'h0c;
  localparam logic [4:0]  REG_IRQ_EDGE_SEL  = 5'h10;

  // Event field layout, shared by live status, irq status, mask and edge select
  localparam int          BIT_TXCLK_LOSS    = 3;
  localparam int          BIT_PATTERN_SYNC  = 4;
  localparam int          BIT_DEACT_CODE    = 5;
  localparam int          BIT_ACT_CODE      = 6;
  localparam int          BIT_REMOTE_LOOP   = 7;
  localparam logic [7:0]  EVENT_BITS        = 8'h78;

  // Control register fields
  localparam int          BIT_AUTO_LOOP_EN  = 0;

  // Reset values
  localparam logic [7:0]  IRQ_MASK_RST      = 8'h78;
  localparam logic [7:0]  IRQ_EDGE_SEL_RST  = 8'h00;
  localparam logic        AUTO_LOOP_EN_RST  = 1'b0;

endpackage

/* src/msi_qual_timer.sv */
// Qualification timer: a status level rises once its detector input has
// stayed high for more than the selected number of cycles.
// Assumes the detector input is already on the core clock.
`timescale 1ns/1ps
module msi_qual_timer #(
  parameter int CNT_W = msi_pkg::QUAL_W
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_sync_b,
  // Detector and period
  input  wire logic             detect,
  input  wire logic [CNT_W-1:0] limit,
  // Qualified level
  output logic                  qualified
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             qual_r;
  logic             qual_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    qual_nxt = 1'b0;
    if (!detect) begin
      cnt_nxt = '0;
    end else if (cnt_r < limit) begin
      cnt_nxt = cnt_r + 1'b1;
    end
    // Set only after limit+1 high cycles, held while the detector holds
    if (detect && (cnt_r >= limit)) begin
      qual_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cnt_r  <= '0;
      qual_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      qual_r <= qual_nxt;
    end
  end

  assign qualified = qual_r;

endmodule

/* src/msi_top.sv */
// Maintenance status and interrupt logic: in-band loopback code status,
// pattern sync status, transmit clock loss, sticky interrupts and the
// remote loopback command, reached over an Avalon-MM slave.
// Assumes detectors and pattern checker run on core_clk; the transmit
// clock arrives from a pin and is synchronised here.
//
// What this block does
// [R1] Activate rising edge interrupts when unmasked, edge-select 0
// [R2] Activate any change interrupts when unmasked, edge-select 1
// [R3] Deactivate status sets after qualified code period
// [R4] Period 40 ms, or 5.1 s with auto loop
// [R5] Deactivate rising edge ends remote loopback
// [R6] Deactivate rising edge interrupts when unmasked, edge-select 0
// [R7] Deactivate any change interrupts when unmasked, edge-select 1
// [R8] Pattern sync status follows checker in real time
// [R9] Pattern sync rising edge interrupts, edge-select 0
// [R10] Pattern sync any change interrupts, edge-select 1
// [R11] Transmit clock loss after 70 idle cycles
// [R12] Activate rising edge starts remote loopback
// [R13] Compare with previous cycle; latch pending events
`timescale 1ns/1ps
module msi_top #(
  parameter int QUAL_SHORT_CYC = msi_pkg::QUAL_SHORT_CYC,
  parameter int QUAL_LONG_CYC  = msi_pkg::QUAL_LONG_CYC
) (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  // Avalon-MM slave
  input  wire logic [msi_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  // Detector levels on core_clk
  input  wire logic                       activate_code_detect,
  input  wire logic                       deactivate_code_detect,
  input  wire logic                       pattern_sync_in,
  // Transmit clock pin
  input  wire logic                       transmit_clock_in,
  // Results
  output logic                            remote_loop_active,
  output logic                            irq
);

  // Reset release through two flip-flops
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_sync_b;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_sync_b = rst_sync_r;

  // Configuration registers
  logic       auto_loop_en_r;
  logic       auto_loop_en_nxt;
  logic [7:0] irq_mask_r;
  logic [7:0] irq_mask_nxt;
  logic [7:0] irq_edge_sel_r;
  logic [7:0] irq_edge_sel_nxt;

  // Names used by the interrupt and code qualification
  logic activate_code_irq_mask;
  logic activate_code_irq_edge_sel;
  logic deactivate_code_irq_mask;
  logic deactivate_code_irq_edge_sel;
  logic pattern_sync_irq_mask;
  logic pattern_sync_irq_edge_sel;
  logic transmit_clock_loss_irq_mask;
  logic auto_remote_loop_switch_en;

  assign activate_code_irq_mask       = irq_mask_r[msi_pkg::BIT_ACT_CODE];
  assign activate_code_irq_edge_sel   = irq_edge_sel_r[msi_pkg::BIT_ACT_CODE];
  assign deactivate_code_irq_mask     = irq_mask_r[msi_pkg::BIT_DEACT_CODE];
  assign deactivate_code_irq_edge_sel = irq_edge_sel_r[msi_pkg::BIT_DEACT_CODE];
  assign pattern_sync_irq_mask        = irq_mask_r[msi_pkg::BIT_PATTERN_SYNC];
  assign pattern_sync_irq_edge_sel    = irq_edge_sel_r[msi_pkg::BIT_PATTERN_SYNC];
  assign transmit_clock_loss_irq_mask = irq_mask_r[msi_pkg::BIT_TXCLK_LOSS];
  assign auto_remote_loop_switch_en   = auto_loop_en_r;

  // In-band code qualification
  logic [msi_pkg::QUAL_W-1:0] qual_limit;
  logic                       activate_code_status;
  logic                       deactivate_code_status;

  // Period follows the automatic loop switch setting; the limit is the full
  // period, so the code must stand one cycle longer than t before it counts
  assign qual_limit = auto_remote_loop_switch_en ?                                   // [R4]
                      msi_pkg::QUAL_W'(QUAL_LONG_CYC) :
                      msi_pkg::QUAL_W'(QUAL_SHORT_CYC);

  msi_qual_timer #(
    .CNT_W      (msi_pkg::QUAL_W)
  ) u_act_qual (
    .clk        (core_clk),
    .rst_sync_b (rst_sync_b),
    .detect     (activate_code_detect),
    .limit      (qual_limit),
    .qualified  (activate_code_status)
  );

  // Detector input high means code present with error rate within limit
  msi_qual_timer #(
    .CNT_W      (msi_pkg::QUAL_W)
  ) u_deact_qual (                                                                   // [R3]
    .clk        (core_clk),
    .rst_sync_b (rst_sync_b),
    .detect     (deactivate_code_detect),
    .limit      (qual_limit),
    .qualified  (deactivate_code_status)
  );

  // Pattern sync is shown as the checker reports it, no filtering
  logic pattern_sync_status;
  assign pattern_sync_status = pattern_sync_in;                                     // [R8]

  // Transmit clock synchroniser and idle counter
  logic                         txclk_meta_r;
  logic                         txclk_sync_r;
  logic                         txclk_last_r;
  logic [msi_pkg::TXCLK_CNT_W-1:0] txclk_idle_r;
  logic [msi_pkg::TXCLK_CNT_W-1:0] txclk_idle_nxt;
  logic                         transmit_clock_loss_r;
  logic                         transmit_clock_loss_nxt;

  always_comb begin
    txclk_idle_nxt          = txclk_idle_r;
    transmit_clock_loss_nxt = 1'b0;
    if (txclk_sync_r != txclk_last_r) begin
      txclk_idle_nxt = '0;
    end else if (txclk_idle_r <= msi_pkg::TXCLK_CNT_W'(msi_pkg::TXCLK_LOSS_CYC)) begin
      txclk_idle_nxt = txclk_idle_r + 1'b1;
    end
    // Saturates one past the threshold, so loss means more than 70 cycles
    if (txclk_idle_nxt > msi_pkg::TXCLK_CNT_W'(msi_pkg::TXCLK_LOSS_CYC)) begin     // [R11]
      transmit_clock_loss_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      txclk_meta_r          <= 1'b0;
      txclk_sync_r          <= 1'b0;
      txclk_last_r          <= 1'b0;
      txclk_idle_r          <= '0;
      transmit_clock_loss_r <= 1'b0;
    end else begin
      txclk_meta_r          <= transmit_clock_in;
      txclk_sync_r          <= txclk_meta_r;
      txclk_last_r          <= txclk_sync_r;
      txclk_idle_r          <= txclk_idle_nxt;
      transmit_clock_loss_r <= transmit_clock_loss_nxt;
    end
  end

  // Live status word and its copy from the previous cycle
  logic [7:0] live_status;
  logic [7:0] live_prev_r;
  logic       remote_loop_r;
  logic       remote_loop_nxt;

  always_comb begin
    live_status                                = 8'h00;
    live_status[msi_pkg::BIT_ACT_CODE]         = activate_code_status;
    live_status[msi_pkg::BIT_DEACT_CODE]       = deactivate_code_status;
    live_status[msi_pkg::BIT_PATTERN_SYNC]     = pattern_sync_status;
    live_status[msi_pkg::BIT_TXCLK_LOSS]       = transmit_clock_loss_r;
    live_status[msi_pkg::BIT_REMOTE_LOOP]      = remote_loop_r;
  end

  function automatic logic rise_of(input logic cur, input logic prev);
    return cur && !prev;
  endfunction

  function automatic logic edge_event(input logic cur, input logic prev,
                                      input logic mask, input logic any_change);
    logic hit;
    hit = any_change ? (cur != prev) : rise_of(cur, prev);
    return hit && !mask;
  endfunction

  // Bus decode
  logic       bus_ack_r;
  logic       bus_ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic       wr_take;
  logic       wr_lane0;
  logic [7:0] wr_byte;

  assign avs_waitrequest = (avs_read || avs_write) && !bus_ack_r;
  assign wr_take         = avs_write && bus_ack_r;
  assign wr_lane0        = wr_take && avs_byteenable[0];
  assign wr_byte         = avs_writedata[7:0];

  // Sticky interrupt status
  logic [7:0] irq_status_r;
  logic [7:0] irq_status_nxt;
  logic [7:0] irq_set;

  always_comb begin
    irq_set = 8'h00;
    irq_set[msi_pkg::BIT_ACT_CODE] =                                                // [R1] [R2]
      edge_event(activate_code_status, live_prev_r[msi_pkg::BIT_ACT_CODE],
                 activate_code_irq_mask, activate_code_irq_edge_sel);
    irq_set[msi_pkg::BIT_DEACT_CODE] =                                              // [R6] [R7]
      edge_event(deactivate_code_status, live_prev_r[msi_pkg::BIT_DEACT_CODE],
                 deactivate_code_irq_mask, deactivate_code_irq_edge_sel);
    irq_set[msi_pkg::BIT_PATTERN_SYNC] =                                            // [R9] [R10]
      edge_event(pattern_sync_status, live_prev_r[msi_pkg::BIT_PATTERN_SYNC],
                 pattern_sync_irq_mask, pattern_sync_irq_edge_sel);
    irq_set[msi_pkg::BIT_TXCLK_LOSS] =
      edge_event(transmit_clock_loss_r, live_prev_r[msi_pkg::BIT_TXCLK_LOSS],
                 transmit_clock_loss_irq_mask, irq_edge_sel_r[msi_pkg::BIT_TXCLK_LOSS]);
  end

  always_comb begin
    irq_status_nxt   = irq_status_r;
    auto_loop_en_nxt = auto_loop_en_r;
    irq_mask_nxt     = irq_mask_r;
    irq_edge_sel_nxt = irq_edge_sel_r;
    if (wr_lane0) begin
      unique case (avs_address)
        msi_pkg::REG_CONTROL:      auto_loop_en_nxt = wr_byte[msi_pkg::BIT_AUTO_LOOP_EN];
        msi_pkg::REG_IRQ_STATUS:   irq_status_nxt   = irq_status_r & ~wr_byte;
        msi_pkg::REG_IRQ_MASK:     irq_mask_nxt     = wr_byte & msi_pkg::EVENT_BITS;
        msi_pkg::REG_IRQ_EDGE_SEL: irq_edge_sel_nxt = wr_byte & msi_pkg::EVENT_BITS;
        default:                   irq_status_nxt   = irq_status_r;
      endcase
    end
    // A new event in the clearing cycle survives the clear
    irq_status_nxt = irq_status_nxt | irq_set;                                      // [R13]
  end

  // Remote loopback: deactivate wins if both rise together
  always_comb begin
    remote_loop_nxt = remote_loop_r;
    if (rise_of(activate_code_status, live_prev_r[msi_pkg::BIT_ACT_CODE])) begin    // [R12]
      remote_loop_nxt = 1'b1;
    end
    if (rise_of(deactivate_code_status, live_prev_r[msi_pkg::BIT_DEACT_CODE])) begin // [R5]
      remote_loop_nxt = 1'b0;
    end
  end

  // Read data captured in the wait cycle, presented at the ack cycle
  always_comb begin
    bus_ack_nxt = (avs_read || avs_write) && !bus_ack_r;
    rdata_nxt   = rdata_r;
    if (avs_read && !bus_ack_r) begin
      rdata_nxt = 32'h0000_0000;
      unique case (avs_address)
        msi_pkg::REG_LIVE_STATUS:  rdata_nxt[7:0] = live_status;
        msi_pkg::REG_CONTROL:      rdata_nxt[msi_pkg::BIT_AUTO_LOOP_EN] = auto_loop_en_r;
        msi_pkg::REG_IRQ_STATUS:   rdata_nxt[7:0] = irq_status_r;
        msi_pkg::REG_IRQ_MASK:     rdata_nxt[7:0] = irq_mask_r;
        msi_pkg::REG_IRQ_EDGE_SEL: rdata_nxt[7:0] = irq_edge_sel_r;
        default:                   rdata_nxt      = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      live_prev_r    <= 8'h00;
      irq_status_r   <= 8'h00;
      auto_loop_en_r <= msi_pkg::AUTO_LOOP_EN_RST;
      irq_mask_r     <= msi_pkg::IRQ_MASK_RST;
      irq_edge_sel_r <= msi_pkg::IRQ_EDGE_SEL_RST;
      remote_loop_r  <= 1'b0;
      bus_ack_r      <= 1'b0;
      rdata_r        <= 32'h0000_0000;
    end else begin
      live_prev_r    <= live_status;                                                // [R13]
      irq_status_r   <= irq_status_nxt;
      auto_loop_en_r <= auto_loop_en_nxt;
      irq_mask_r     <= irq_mask_nxt;
      irq_edge_sel_r <= irq_edge_sel_nxt;
      remote_loop_r  <= remote_loop_nxt;
      bus_ack_r      <= bus_ack_nxt;
      rdata_r        <= rdata_nxt;
    end
  end

  // Mask gates the latch, so a masked event never pends
  assign irq                = |(irq_status_r & ~irq_mask_r & msi_pkg::EVENT_BITS);
  assign remote_loop_active = remote_loop_r;
  assign avs_readdata       = rdata_r;

endmodule

/* tb/msi_top_monitor.sv */
// Port checker for the maintenance status and interrupt logic.
// Assumes the bus master holds each request until waitrequest is low.
`timescale 1ns/1ps
module msi_top_monitor (
  // Clock and reset
  input wire logic                       core_clk,
  input wire logic                       rst_b,
  // Avalon-MM slave
  input wire logic [msi_pkg::ADDR_W-1:0] avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [31:0]                avs_writedata,
  input wire logic [3:0]                 avs_byteenable,
  input wire logic [31:0]                avs_readdata,
  input wire logic                       avs_waitrequest,
  // Detectors and pin
  input wire logic                       activate_code_detect,
  input wire logic                       deactivate_code_detect,
  input wire logic                       pattern_sync_in,
  input wire logic                       transmit_clock_in,
  // Results
  input wire logic                       remote_loop_active,
  input wire logic                       irq
);
  default clocking mon_cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Cycles since the transmit pin last changed, saturating
  logic [7:0] idle_r;
  logic [7:0] idle_nxt;
  logic       tx_last_r;
  logic       tx_last_nxt;
  always_comb begin
    tx_last_nxt = transmit_clock_in;
    idle_nxt    = (transmit_clock_in != tx_last_r) ? 8'h00 :
                  (idle_r == 8'hff) ? idle_r : idle_r + 8'h01;
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_r    <= 8'h00;
      tx_last_r <= 1'b0;
    end else begin
      idle_r    <= idle_nxt;
      tx_last_r <= tx_last_nxt;
    end
  end
  wire rd_done = avs_read && !avs_waitrequest;
  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  unmapped_zero_a: assert property (rd_done && avs_address > 5'h10 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (rd_done |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  sync_live_a: assert property (
    rd_done && avs_address == 5'h00 |-> avs_readdata[4] == $past(pattern_sync_in))
    else $error("pattern sync not live");
  loop_start_a: assert property ($rose(remote_loop_active) |-> $past(activate_code_detect, 2))
    else $error("loopback started without activate code");
  loop_end_a: assert property ($fell(remote_loop_active) |-> $past(deactivate_code_detect, 2))
    else $error("loopback ended without deactivate code");
  loss_clear_a: assert property (
    rd_done && avs_address == 5'h00 && idle_r inside {[8'd8:8'd60]} |-> !avs_readdata[3])
    else $error("clock loss shown too early");
  loss_set_a: assert property (
    rd_done && avs_address == 5'h00 && idle_r >= 8'd90 |-> avs_readdata[3])
    else $error("clock loss not shown");
  irq_sticky_a: assert property (irq && !avs_write |=> irq)
    else $error("interrupt dropped without service");
endmodule
bind msi_top msi_top_monitor msi_top_monitor_i (
  .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .activate_code_detect(activate_code_detect), .deactivate_code_detect(deactivate_code_detect),
  .pattern_sync_in(pattern_sync_in), .transmit_clock_in(transmit_clock_in),
  .remote_loop_active(remote_loop_active), .irq(irq));

/* tb/tb_msi_top.sv */
// Self-checking bench for the maintenance status and interrupt logic.
// Assumes short qualification periods set through the top parameters.
`timescale 1ns/1ps
module tb_msi_top;
  localparam int QS = 20;
  localparam int QL = 50;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        act_det = 1'b0;
  logic        deact_det = 1'b0;
  logic        sync_in = 1'b0;
  logic        tx_clk = 1'b0;
  logic        tx_run = 1'b0;
  logic        loop_act;
  logic        irq;
  logic [31:0] q;
  logic        m;
  logic        e;
  integer      seed = 32'h8896;
  int          fail_count = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [4:0]  ra [5] = '{5'h0c, 5'h10, 5'h04, 5'h08, 5'h14};
  logic [7:0]  rv [5] = '{8'h78, 8'h00, 8'h00, 8'h00, 8'h00};
  msi_top #(.QUAL_SHORT_CYC(QS), .QUAL_LONG_CYC(QL)) msi_top_i (
    .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .activate_code_detect(act_det), .deactivate_code_detect(deact_det),
    .pattern_sync_in(sync_in), .transmit_clock_in(tx_clk),
    .remote_loop_active(loop_act), .irq(irq));
  always #50 core_clk = ~core_clk;
  // Random toggle gaps keep the pin alive without a fixed rhythm
  always @(posedge core_clk) begin
    if (tx_run && $random(seed) % 2 == 0) tx_clk <= ~tx_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      $display("[ERR] %0t timeout", $time);
      results();
    end
  end
  task automatic results;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] rd);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic src(input int b, input logic v);
    case (b)
      6: act_det <= v;
      5: deact_det <= v;
      default: sync_in <= v;
    endcase
    repeat (60) @(posedge core_clk);
  endtask
  function automatic logic exp_latch(input logic mk, input logic es, input logic rise);
    return !mk && (rise || es);
  endfunction
  initial begin
    repeat (16) @(posedge core_clk);
    rst_b  <= 1'b1;
    tx_run <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 8'h00, q);
      chk(q, {24'h0, rv[i]}, "reset value");
    end
    avs_byteenable <= 4'he;
    bus(1'b1, 5'h0c, 8'h00, q);
    avs_byteenable <= 4'hf;
    bus(1'b0, 5'h0c, 8'h00, q);
    chk(q, 32'h78, "byteenable ignored");
    for (int b = 6; b >= 4; b--) begin
      for (int es = 0; es < 2; es++) begin
        m = 1'($random(seed));
        e = es[0];
        bus(1'b1, 5'h0c, 8'h78 & ~({7'h0, ~m} << b), q);
        bus(1'b1, 5'h10, {7'h0, e} << b, q);
        bus(1'b1, 5'h08, 8'hff, q);
        src(b, 1'b1);
        bus(1'b0, 5'h00, 8'h00, q);
        chk({31'h0, q[b]}, 32'h1, "live status up");
        bus(1'b0, 5'h08, 8'h00, q);
        chk({31'h0, q[b]}, {31'h0, exp_latch(m, e, 1'b1)}, "rise latch");
        chk({31'h0, irq}, {31'h0, exp_latch(m, e, 1'b1)}, "irq on rise");
        if (b == 6) chk({31'h0, loop_act}, 32'h1, "loop start");
        if (b == 5) chk({31'h0, loop_act}, 32'h0, "loop end");
        bus(1'b1, 5'h08, 8'hff, q);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        src(b, 1'b0);
        bus(1'b0, 5'h08, 8'h00, q);
        chk({31'h0, q[b]}, {31'h0, exp_latch(m, e, 1'b0)}, "fall latch");
      end
    end
    for (int a = 0; a < 2; a++) begin
      bus(1'b1, 5'h04, 8'(a), q);
      deact_det <= 1'b1;
      // First read samples the status right after exactly t of code
      repeat (a == 1 ? QL : QS) @(posedge core_clk);
      bus(1'b0, 5'h00, 8'h00, q);
      chk({31'h0, q[5]}, 32'h0, "status before period");
      bus(1'b0, 5'h00, 8'h00, q);
      chk({31'h0, q[5]}, 32'h1, "status after period");
      deact_det <= 1'b0;
      repeat (5) @(posedge core_clk);
    end
    bus(1'b1, 5'h0c, 8'h70, q);
    bus(1'b1, 5'h08, 8'hff, q);
    tx_run <= 1'b0;
    repeat (30) @(posedge core_clk);
    bus(1'b0, 5'h00, 8'h00, q);
    chk({31'h0, q[3]}, 32'h0, "clock loss early");
    repeat (70) @(posedge core_clk);
    bus(1'b0, 5'h00, 8'h00, q);
    chk({31'h0, q[3]}, 32'h1, "clock loss set");
    chk({31'h0, irq}, 32'h1, "clock loss irq");
    bus(1'b1, 5'h10, 8'h08, q);
    bus(1'b1, 5'h08, 8'hff, q);
    chk({31'h0, irq}, 32'h0, "clock loss irq cleared");
    tx_run <= 1'b1;
    repeat (20) @(posedge core_clk);
    bus(1'b0, 5'h00, 8'h00, q);
    chk({31'h0, q[3]}, 32'h0, "clock loss clear");
    bus(1'b0, 5'h08, 8'h00, q);
    chk({31'h0, q[3]}, 32'h1, "clock loss fall latch");
    chk({31'h0, irq}, 32'h1, "clock loss fall irq");
    results();
  end
endmodule
